// >>> design/loop_cfg_pkg.sv
// Purpose: constants for the fractional loop configuration block
// Assumes: apb with 32-bit data, word-aligned registers
// Notes: offsets are byte addresses
package loop_cfg_pkg;
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_MULT = 12'h004;
   localparam logic [11:0] OFF_NUM = 12'h008;
   localparam logic [11:0] OFF_DEN = 12'h00C;
   localparam logic [11:0] OFF_RATIO = 12'h010;
   localparam logic [11:0] OFF_SMULT = 12'h014;
   localparam logic [11:0] OFF_SNUM = 12'h018;
   localparam logic [11:0] OFF_SDEN = 12'h01C;
   localparam logic [11:0] OFF_SRATIO = 12'h020;
   localparam logic [11:0] OFF_ACTIVE = 12'h024;
   localparam logic [11:0] OFF_STATUS = 12'h028;
   // control: bit0 loop enable, bit1 sync enable, bit15 apply strobe
   localparam int CTRL_ENA_BIT = 0;
   localparam int CTRL_SYNC_BIT = 1;
   localparam int CTRL_APPLY_BIT = 15;
   // ratio reg: [3:0] primary ratio, [7:4] gain, [9:8] predivider
   localparam int RATIO_LSB = 0;
   localparam int GAIN_LSB = 4;
   localparam int PREDIV_LSB = 8;
   // sync ratio reg: [2:0] ratio, [7:4] gain, [8] bandwidth, [11:10] predivider
   localparam int SRATIO_LSB = 0;
   localparam int SGAIN_LSB = 4;
   localparam int SBW_BIT = 8;
   localparam int SPREDIV_LSB = 10;
   localparam logic [9:0] MULT_RST = 10'h008;
   localparam logic [15:0] NUM_RST = 16'h0018;
   localparam logic [15:0] DEN_RST = 16'h007D;
   localparam logic [3:0] RATIO_RST = 4'h0;
   localparam logic [3:0] GAIN_RST = 4'h0;
   localparam logic [1:0] PREDIV_RST = 2'h0;
   localparam logic [9:0] SMULT_RST = 10'h000;
   localparam logic [15:0] SNUM_RST = 16'h0000;
   localparam logic [15:0] SDEN_RST = 16'h0000;
   localparam logic [2:0] SRATIO_RST = 3'h0;
   localparam logic [4:0] SYNC_RATIO_MAX = 5'h10;
   typedef enum logic [0:0] {
      FRAC_RATIONAL = 1'b0,
      FRAC_BINARY16 = 1'b1
   } frac_mode_t;
endpackage

// >>> design/apply_stage.sv
// Purpose: active multiplier pair with staged apply
// Assumes: loads come from the apb write path
// Notes: pair changes in one edge on apply; with the loop disabled each direct write loads one member
`timescale 1ns/10ps
module apply_stage (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic loop_enable,
   input wire logic apply_pulse,
   input wire logic direct_mult_we,
   input wire logic direct_num_we,
   // staged values
   input wire logic [9:0] pend_mult,
   input wire logic [15:0] pend_num,
   // active pair
   output logic [9:0] act_mult,
   output logic [15:0] act_num
);
   import loop_cfg_pkg::*;
   logic [9:0] mult_r, mult_nxt;
   logic [15:0] num_r, num_nxt;
   always_comb begin
      mult_nxt = mult_r;
      num_nxt = num_r;
      if (!loop_enable) begin
         if (direct_mult_we) mult_nxt = pend_mult;
         if (direct_num_we) num_nxt = pend_num;
      end else if (apply_pulse) begin
         mult_nxt = pend_mult;
         num_nxt = pend_num;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mult_r <= MULT_RST;
         num_r <= NUM_RST;
      end else begin
         mult_r <= mult_nxt;
         num_r <= num_nxt;
      end
   end
   assign act_mult = mult_r;
   assign act_num = num_r;
endmodule

// >>> design/fractional_loop_config.sv
// Purpose: register file and parameter update for a fractional locked loop
// Assumes: apb slave, zero wait states, registers at word offsets
// Notes: decoded ratios and fraction mode drive the analog loop
`timescale 1ns/10ps
module fractional_loop_config (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // loop settings
   output logic loop_enable,
   output logic sync_path_enable,
   output logic [9:0] integer_multiplier,
   output logic [15:0] fraction_numerator,
   output logic [15:0] fraction_denominator,
   output logic [4:0] primary_divide_ratio,
   output logic [3:0] primary_loop_gain,
   output logic [1:0] primary_ref_predivider,
   output loop_cfg_pkg::frac_mode_t frac_mode,
   // synchroniser settings
   output logic [9:0] sync_integer_multiplier,
   output logic [15:0] sync_fraction_numerator,
   output logic [15:0] sync_fraction_denominator,
   output logic [4:0] sync_divide_ratio,
   output logic [3:0] sync_loop_gain,
   output logic sync_bandwidth_select,
   output logic [1:0] sync_ref_predivider
);
   import loop_cfg_pkg::*;

   function automatic logic [4:0] dec_primary(input logic [3:0] code);
      dec_primary = {1'b0, code} + 5'h01;
   endfunction

   function automatic logic [4:0] dec_sync(input logic [2:0] code);
      if (code[2]) dec_sync = SYNC_RATIO_MAX;
      else dec_sync = 5'(5'h01 << code[1:0]);
   endfunction

   logic ena_r, ena_nxt, sena_r, sena_nxt;
   logic [9:0] pmult_r, pmult_nxt, smult_r, smult_nxt;
   logic [15:0] pnum_r, pnum_nxt, den_r, den_nxt, snum_r, snum_nxt, sden_r, sden_nxt;
   logic [3:0] ratio_r, ratio_nxt, gain_r, gain_nxt, sgain_r, sgain_nxt;
   logic [1:0] prediv_r, prediv_nxt, sprediv_r, sprediv_nxt;
   logic [2:0] sratio_r, sratio_nxt;
   logic sbw_r, sbw_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic slverr_r, slverr_nxt;
   logic apply_r, apply_nxt, mwe_r, mwe_nxt, nwe_r, nwe_nxt;
   logic [9:0] act_mult;
   logic [15:0] act_num;
   logic wr, setup, rd_setup, hit;
   logic pready_r, pready_nxt;

   assign wr = psel && penable && pwrite;
   // read data and error load in setup, so they stand in the access cycle
   assign setup = psel && !penable;
   assign rd_setup = setup && !pwrite;

   always_comb begin
      ena_nxt = ena_r;
      sena_nxt = sena_r;
      pmult_nxt = pmult_r;
      pnum_nxt = pnum_r;
      den_nxt = den_r;
      ratio_nxt = ratio_r;
      gain_nxt = gain_r;
      prediv_nxt = prediv_r;
      smult_nxt = smult_r;
      snum_nxt = snum_r;
      sden_nxt = sden_r;
      sratio_nxt = sratio_r;
      sgain_nxt = sgain_r;
      sbw_nxt = sbw_r;
      sprediv_nxt = sprediv_r;
      rdata_nxt = rdata_r;
      slverr_nxt = 1'b0;
      apply_nxt = 1'b0;
      mwe_nxt = 1'b0;
      nwe_nxt = 1'b0;
      hit = 1'b1;
      if (paddr == OFF_CTRL) begin
         if (wr) begin
            ena_nxt = pwdata[CTRL_ENA_BIT];
            sena_nxt = pwdata[CTRL_SYNC_BIT];
            apply_nxt = pwdata[CTRL_APPLY_BIT] && ena_r;
         end
         rdata_nxt = {30'h0, sena_r, ena_r};
      end else if (paddr == OFF_MULT) begin
         if (wr) pmult_nxt = pwdata[9:0];
         mwe_nxt = wr;
         rdata_nxt = {22'h0, pmult_r};
      end else if (paddr == OFF_NUM) begin
         if (wr) pnum_nxt = pwdata[15:0];
         nwe_nxt = wr;
         rdata_nxt = {16'h0, pnum_r};
      end else if (paddr == OFF_DEN) begin
         if (wr) den_nxt = pwdata[15:0];
         rdata_nxt = {16'h0, den_r};
      end else if (paddr == OFF_RATIO) begin
         if (wr) begin
            ratio_nxt = pwdata[RATIO_LSB +: 4];
            gain_nxt = pwdata[GAIN_LSB +: 4];
            prediv_nxt = pwdata[PREDIV_LSB +: 2];
         end
         rdata_nxt = {22'h0, prediv_r, gain_r, ratio_r};
      end else if (paddr == OFF_SMULT) begin
         if (wr) smult_nxt = pwdata[9:0];
         rdata_nxt = {22'h0, smult_r};
      end else if (paddr == OFF_SNUM) begin
         if (wr) snum_nxt = pwdata[15:0];
         rdata_nxt = {16'h0, snum_r};
      end else if (paddr == OFF_SDEN) begin
         if (wr) sden_nxt = pwdata[15:0];
         rdata_nxt = {16'h0, sden_r};
      end else if (paddr == OFF_SRATIO) begin
         if (wr) begin
            sratio_nxt = pwdata[SRATIO_LSB +: 3];
            sgain_nxt = pwdata[SGAIN_LSB +: 4];
            sbw_nxt = pwdata[SBW_BIT];
            sprediv_nxt = pwdata[SPREDIV_LSB +: 2];
         end
         rdata_nxt = {20'h0, sprediv_r, 1'b0, sbw_r, sgain_r, 1'b0, sratio_r};
      end else if (paddr == OFF_ACTIVE) begin
         rdata_nxt = {6'h0, act_mult, act_num};
      end else if (paddr == OFF_STATUS) begin
         rdata_nxt = {22'h0, primary_divide_ratio, sync_divide_ratio};
      end else begin
         hit = 1'b0;
         rdata_nxt = 32'h0;
      end
      if (!rd_setup) rdata_nxt = rdata_r;
      if (setup && !hit) slverr_nxt = 1'b1;
      pready_nxt = setup;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ena_r <= 1'b0;
         sena_r <= 1'b0;
         pmult_r <= MULT_RST;
         pnum_r <= NUM_RST;
         den_r <= DEN_RST;
         ratio_r <= RATIO_RST;
         gain_r <= GAIN_RST;
         prediv_r <= PREDIV_RST;
         smult_r <= SMULT_RST;
         snum_r <= SNUM_RST;
         sden_r <= SDEN_RST;
         sratio_r <= SRATIO_RST;
         sgain_r <= GAIN_RST;
         sbw_r <= 1'b0;
         sprediv_r <= PREDIV_RST;
         rdata_r <= 32'h0;
         slverr_r <= 1'b0;
         pready_r <= 1'b0;
         apply_r <= 1'b0;
         mwe_r <= 1'b0;
         nwe_r <= 1'b0;
      end else begin
         ena_r <= ena_nxt;
         sena_r <= sena_nxt;
         pmult_r <= pmult_nxt;
         pnum_r <= pnum_nxt;
         den_r <= den_nxt;
         ratio_r <= ratio_nxt;
         gain_r <= gain_nxt;
         prediv_r <= prediv_nxt;
         smult_r <= smult_nxt;
         snum_r <= snum_nxt;
         sden_r <= sden_nxt;
         sratio_r <= sratio_nxt;
         sgain_r <= sgain_nxt;
         sbw_r <= sbw_nxt;
         sprediv_r <= sprediv_nxt;
         rdata_r <= rdata_nxt;
         slverr_r <= slverr_nxt;
         pready_r <= pready_nxt;
         apply_r <= apply_nxt;
         mwe_r <= mwe_nxt;
         nwe_r <= nwe_nxt;
      end
   end

   apply_stage u_apply (
      .pclk(pclk),
      .presetn(presetn),
      .loop_enable(ena_r),
      .apply_pulse(apply_r),
      .direct_mult_we(mwe_r),
      .direct_num_we(nwe_r),
      .pend_mult(pmult_r),
      .pend_num(pnum_r),
      .act_mult(act_mult),
      .act_num(act_num)
   );

   // registered outputs, straight from flip-flops
   logic [4:0] pratio_dec_r, sratio_dec_r;
   logic [15:0] den_out_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pratio_dec_r <= 5'h01;
         sratio_dec_r <= 5'h01;
         den_out_r <= DEN_RST;
      end else begin
         pratio_dec_r <= dec_primary(ratio_r);
         sratio_dec_r <= dec_sync(sratio_r);
         den_out_r <= sena_r ? 16'h0000 : den_r;
      end
   end

   assign prdata = rdata_r;
   assign pready = pready_r;
   assign pslverr = slverr_r;
   assign loop_enable = ena_r;
   assign sync_path_enable = sena_r;
   assign integer_multiplier = act_mult;
   assign fraction_numerator = act_num;
   assign fraction_denominator = den_out_r;
   assign primary_divide_ratio = pratio_dec_r;
   assign primary_loop_gain = gain_r;
   assign primary_ref_predivider = prediv_r;
   assign frac_mode = sena_r ? FRAC_BINARY16 : FRAC_RATIONAL;
   assign sync_integer_multiplier = smult_r;
   assign sync_fraction_numerator = snum_r;
   assign sync_fraction_denominator = sden_r;
   assign sync_divide_ratio = sratio_dec_r;
   assign sync_loop_gain = sgain_r;
   assign sync_bandwidth_select = sbw_r;
   assign sync_ref_predivider = sprediv_r;
endmodule

// >>> test/apb_host.sv
// Purpose: register host model driving apb
// Assumes: called just after a rising edge
// Notes: read data and error taken at the access edge
`timescale 1ns/10ps
module apb_host (
   // apb
   input wire logic pclk,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// >>> test/loop_cfg_chk.sv
// Purpose: port checks for the loop configuration block
// Assumes: zero wait state apb
// Notes: bound to the top module
`timescale 1ns/10ps
module loop_cfg_chk (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pslverr,
   // loop settings
   input wire logic loop_enable,
   input wire logic sync_path_enable,
   input wire logic [9:0] integer_multiplier,
   input wire logic [15:0] fraction_numerator,
   input wire logic [15:0] fraction_denominator,
   input wire logic [4:0] primary_divide_ratio,
   input wire logic [4:0] sync_divide_ratio,
   input wire loop_cfg_pkg::frac_mode_t frac_mode
);
   import loop_cfg_pkg::*;
   logic wr;
   logic [9:0] pm_q;
   logic [15:0] pn_q;
   assign wr = psel && penable && pwrite;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pm_q <= MULT_RST;
         pn_q <= NUM_RST;
      end else if (wr) begin
         pm_q <= (paddr == OFF_MULT) ? pwdata[9:0] : pm_q;
         pn_q <= (paddr == OFF_NUM) ? pwdata[15:0] : pn_q;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ratio_plus_one: assert property (wr && paddr == OFF_RATIO |=> ##1
      primary_divide_ratio == {1'b0, $past(pwdata[3:0], 2)} + 5'h01) else $error("primary ratio decode wrong");
   a_sync_pow_two: assert property (wr && paddr == OFF_SRATIO |=> ##1
      sync_divide_ratio == ($past(pwdata[2], 2) ? 5'h10 : 5'h01 << $past(pwdata[1:0], 2)))
      else $error("sync ratio decode wrong");
   a_hold_pending: assert property (loop_enable && wr && paddr == OFF_MULT |=> ##1
      $stable(integer_multiplier)) else $error("multiplier changed without apply");
   a_direct_write: assert property (!loop_enable && wr && paddr == OFF_MULT |=> ##1
      integer_multiplier == $past(pwdata[9:0], 2)) else $error("direct multiplier write lost");
   a_apply_pair: assert property (loop_enable && wr && paddr == OFF_CTRL && pwdata[CTRL_APPLY_BIT] |=> ##1
      integer_multiplier == pm_q && fraction_numerator == pn_q) else $error("apply pair wrong");
   a_zero_inert: assert property (loop_enable && wr && paddr == OFF_CTRL && pwdata[1:0] == 2'h1 &&
      !pwdata[CTRL_APPLY_BIT] |=> ##1 $stable(integer_multiplier) && $stable(fraction_numerator))
      else $error("apply without strobe");
   a_den_ignored: assert property (sync_path_enable [*2] |-> fraction_denominator == 16'h0000)
      else $error("denominator used with sync");
   a_binary_frac: assert property (frac_mode == (sync_path_enable ? FRAC_BINARY16 : FRAC_RATIONAL))
      else $error("fraction mode wrong");
   a_unmapped_err: assert property (psel && !penable && paddr > OFF_STATUS |=> pslverr)
      else $error("no error on unmapped access");
   c_apply: cover property (loop_enable && wr && paddr == OFF_CTRL && pwdata[CTRL_APPLY_BIT]);
   c_direct: cover property (!loop_enable && wr && paddr == OFF_MULT);
   c_sync: cover property (sync_path_enable && frac_mode == FRAC_BINARY16);
endmodule
bind fractional_loop_config loop_cfg_chk loop_cfg_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pslverr, .loop_enable, .sync_path_enable, .integer_multiplier, .fraction_numerator,
   .fraction_denominator, .primary_divide_ratio, .sync_divide_ratio, .frac_mode);

// >>> test/fractional_loop_config_tb.sv
// Purpose: register level tests of the loop configuration block
// Assumes: outputs checked two edges after an access
// Notes: host values follow the band tables
`timescale 1ns/10ps
module fractional_loop_config_tb;
   import loop_cfg_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, err, loop_enable, sync_path_enable, sync_bandwidth_select;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [9:0] integer_multiplier, sync_integer_multiplier;
   logic [1:0] primary_ref_predivider, sync_ref_predivider;
   logic [15:0] fraction_numerator, fraction_denominator;
   logic [4:0] primary_divide_ratio, sync_divide_ratio;
   logic [3:0] primary_loop_gain;
   frac_mode_t frac_mode;
   int bad_count = 0;
   int tests_run = 0;
   int cyc = 0;
   always #20 pclk = ~pclk;
   apb_host apb_host_inst (.pclk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata);
   fractional_loop_config fractional_loop_config_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .loop_enable, .sync_path_enable, .integer_multiplier,
      .fraction_numerator, .fraction_denominator, .primary_divide_ratio, .primary_loop_gain,
      .primary_ref_predivider, .frac_mode, .sync_integer_multiplier, .sync_fraction_numerator(),
      .sync_fraction_denominator(), .sync_divide_ratio, .sync_loop_gain(), .sync_bandwidth_select,
      .sync_ref_predivider);
   task automatic close_out;
      if (bad_count == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb_host_inst.xfer(1'b1, a, d, rd, err);
      repeat (2) @(posedge pclk);
   endtask
   task automatic rg(input logic [11:0] a, input logic [31:0] exp);
      apb_host_inst.xfer(1'b0, a, 32'h0, rd, err);
      chk(rd, exp);
      @(posedge pclk);
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 1000) begin
         bad_count++;
         close_out;
      end
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rg(OFF_ACTIVE, 32'h0008_0018);
      chk(fraction_denominator, 32'h7D);
      for (int c = 0; c < 16; c++) begin
         wr(OFF_RATIO, 32'(c) | 32'(c) << 4);
         chk(primary_divide_ratio, 32'(c + 1));
         chk(primary_loop_gain, 32'(c));
      end
      wr(OFF_RATIO, 32'h0000_0240);
      chk(primary_ref_predivider, 32'h2);
      for (int c = 0; c < 8; c++) begin
         wr(OFF_SRATIO, 32'(c));
         chk(sync_divide_ratio, c > 3 ? 32'h10 : 32'h1 << c);
      end
      wr(OFF_SRATIO, 32'h0000_0503);
      chk(sync_bandwidth_select, 32'h1);
      chk(sync_ref_predivider, 32'h1);
      wr(OFF_SMULT, 32'h0000_02A5);
      chk(sync_integer_multiplier, 32'h2A5);
      wr(OFF_MULT, 32'h0000_0123);
      wr(OFF_NUM, 32'h0000_0155);
      wr(OFF_DEN, 32'h0000_0200);
      rg(OFF_ACTIVE, 32'h0123_0155);
      chk(fraction_denominator, 32'h200);
      wr(OFF_CTRL, 32'h0000_0001);
      wr(OFF_MULT, 32'h0000_00AB);
      wr(OFF_NUM, 32'h0000_0101);
      chk({integer_multiplier, fraction_numerator}, 32'h0123_0155);
      wr(OFF_CTRL, 32'h0000_0001);
      chk(integer_multiplier, 32'h123);
      rg(OFF_MULT, 32'h0000_00AB);
      wr(OFF_CTRL, 32'h0000_8001);
      chk({integer_multiplier, fraction_numerator}, 32'h00AB_0101);
      rg(OFF_CTRL, 32'h0000_0001);
      wr(OFF_MULT, 32'h0000_00CC);
      wr(OFF_CTRL, 32'h0000_0000);
      wr(OFF_CTRL, 32'h0000_8000);
      chk(loop_enable, 32'h0);
      chk(integer_multiplier, 32'hAB);
      wr(OFF_CTRL, 32'h0000_0002);
      wr(OFF_NUM, 32'h0000_8000);
      chk(fraction_denominator, 32'h0);
      chk({frac_mode, fraction_numerator}, {15'h0, FRAC_BINARY16, 16'h8000});
      wr(12'h030, 32'hFFFF_FFFF);
      chk(err, 32'h1);
      rg(12'h030, 32'h0);
      chk(sync_path_enable, 32'h1);
      close_out;
   end
endmodule
